// ==== pisr_host.sv ====
// Host end: programs the mandatory proximity settings after reset and forwards user register commands.
// Assumes the device end answers a read one cycle after the read strobe.
`timescale 1ns/10ps
`include "pisr_regs.svh"
module pisr_host
   import pisr_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // Register access
   pisr_reg_if.host         bus,
   // User command port
   input  wire logic        cmd_valid,
   input  wire logic        cmd_write,
   input  wire pisr_byte_t  cmd_addr,
   input  wire pisr_byte_t  cmd_wdata,
   output logic             cmd_ready,
   // User answer port
   output logic             resp_valid,
   output logic             resp_refused,
   output pisr_byte_t       resp_data,
   // System context
   input  wire logic        touchscreen_is_sensor,
   input  wire logic        prox_conversion_done,
   output logic             init_done
);

   // ****************************************************************
   // State
   // ****************************************************************
   pisr_host_st_e st_r,      st_nxt;
   pisr_byte_t    addr_r,    addr_nxt;
   pisr_byte_t    wdata_r,   wdata_nxt;
   logic          wr_r,      wr_nxt;
   logic          rd_r,      rd_nxt;
   logic          rv_r,      rv_nxt;
   logic          ref_r,     ref_nxt;
   pisr_byte_t    rsp_r,     rsp_nxt;
   logic          done_r,    done_nxt;

   logic          bad;
   pisr_byte_t    wr_val;

   // ****************************************************************
   // Command checking and sequencing
   // ****************************************************************
   always_comb
   begin
      st_nxt    = st_r;
      addr_nxt  = addr_r;
      wdata_nxt = wdata_r;
      wr_nxt    = 1'b0;
      rd_nxt    = 1'b0;
      rv_nxt    = 1'b0;
      ref_nxt   = 1'b0;
      rsp_nxt   = rsp_r;
      done_nxt  = done_r | prox_conversion_done;
      wr_val    = cmd_wdata;
      bad       = 1'b0;
      if (cmd_write)
      begin
         if (cmd_addr == `PISR_ADDR_COMP_OFFSET_LOW)
            bad = 1'b1;
         if ((cmd_addr == `PISR_ADDR_GAIN_FREQ_CFG) &&
             !((cmd_wdata[`PISR_FREQ_MSB:`PISR_FREQ_LSB] == `PISR_FREQ_64K) ||
               (cmd_wdata[`PISR_FREQ_MSB:`PISR_FREQ_LSB] == `PISR_FREQ_90K) ||
               (cmd_wdata[`PISR_FREQ_MSB:`PISR_FREQ_LSB] == `PISR_FREQ_112K) ||
               (cmd_wdata[`PISR_FREQ_MSB:`PISR_FREQ_LSB] == `PISR_FREQ_150K)))
            bad = 1'b1;
         if (cmd_addr == `PISR_ADDR_BOOST_CFG)
         begin
            if ((cmd_wdata[`PISR_BOOST_MSB:`PISR_BOOST_LSB] != `PISR_BOOST_ON) &&
                (cmd_wdata[`PISR_BOOST_MSB:`PISR_BOOST_LSB] != `PISR_BOOST_OFF))
               bad = 1'b1;
            if (touchscreen_is_sensor)
               wr_val[`PISR_BOOST_MSB:`PISR_BOOST_LSB] = `PISR_BOOST_OFF;
            wr_val[`PISR_BOOST_LOW_MSB:`PISR_BOOST_LOW_LSB] = `PISR_BOOST_LOW_REQUIRED;
         end
      end
      else if ((cmd_addr == `PISR_ADDR_COMP_OFFSET_LOW) && !done_r)
         bad = 1'b1;
      case (st_r)
         HS_INIT_FREQ:
         begin
            addr_nxt  = `PISR_ADDR_GAIN_FREQ_CFG;
            wdata_nxt = `PISR_INIT_GAIN_FREQ;
            wr_nxt    = 1'b1;
            st_nxt    = HS_INIT_BOOST;
         end
         HS_INIT_BOOST:
         begin
            addr_nxt  = `PISR_ADDR_BOOST_CFG;
            wdata_nxt = `PISR_INIT_BOOST;
            wr_nxt    = 1'b1;
            st_nxt    = HS_INIT_TRIM;
         end
         HS_INIT_TRIM:
         begin
            addr_nxt  = `PISR_ADDR_RESERVED_TRIM;
            wdata_nxt = `PISR_TRIM_REQUIRED;
            wr_nxt    = 1'b1;
            st_nxt    = HS_IDLE;
         end
         HS_IDLE:
         begin
            if (cmd_valid)
            begin
               if (bad)
               begin
                  rv_nxt  = 1'b1;
                  ref_nxt = 1'b1;
               end
               else if (cmd_write)
               begin
                  addr_nxt  = cmd_addr;
                  wdata_nxt = wr_val;
                  wr_nxt    = 1'b1;
                  rv_nxt    = 1'b1;
               end
               else
               begin
                  addr_nxt = cmd_addr;
                  rd_nxt   = 1'b1;
                  st_nxt   = HS_READ;
                  if (cmd_addr == `PISR_ADDR_COMP_OFFSET_LOW)
                     done_nxt = prox_conversion_done;
               end
            end
         end
         HS_READ:
         begin
            if (bus.reg_rvalid)
            begin
               rsp_nxt = bus.reg_rdata;
               rv_nxt  = 1'b1;
               st_nxt  = HS_IDLE;
            end
         end
         default:
            st_nxt = HS_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         st_r    <= HS_INIT_FREQ;
         addr_r  <= 8'h00;
         wdata_r <= 8'h00;
         wr_r    <= 1'b0;
         rd_r    <= 1'b0;
         rv_r    <= 1'b0;
         ref_r   <= 1'b0;
         rsp_r   <= 8'h00;
         done_r  <= 1'b0;
      end
      else
      begin
         st_r    <= st_nxt;
         addr_r  <= addr_nxt;
         wdata_r <= wdata_nxt;
         wr_r    <= wr_nxt;
         rd_r    <= rd_nxt;
         rv_r    <= rv_nxt;
         ref_r   <= ref_nxt;
         rsp_r   <= rsp_nxt;
         done_r  <= done_nxt;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign bus.reg_addr  = addr_r;
   assign bus.reg_wdata = wdata_r;
   assign bus.reg_wr    = wr_r;
   assign bus.reg_rd    = rd_r;
   assign cmd_ready     = (st_r == HS_IDLE);
   assign resp_valid    = rv_r;
   assign resp_refused  = ref_r;
   assign resp_data     = rsp_r;
   assign init_done     = (st_r == HS_IDLE) || (st_r == HS_READ);

endmodule : pisr_host

// ==== pisr_regs.svh ====
// Register offsets, field positions, reset values and codes of the proximity/interrupt register block.
// Assumes inclusion by bare name from every file that decodes the register map.
`ifndef PISR_REGS_SVH
`define PISR_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PISR_ADDR_COMP_OFFSET_LOW   8'h1C
`define PISR_ADDR_GAIN_FREQ_CFG     8'h1D
`define PISR_ADDR_BOOST_CFG         8'h1F
`define PISR_ADDR_RESERVED_TRIM     8'h20
`define PISR_ADDR_RESERVED_SPARE    8'h21
`define PISR_ADDR_INT_ENABLE_MASK   8'h22
`define PISR_ADDR_INT_SOURCE_FLAGS  8'h23
`define PISR_ADDR_DEVICE_STATUS     8'h24

// ****************************************************************
// Reset values
// ****************************************************************
`define PISR_RST_GAIN_FREQ_CFG      8'h00
`define PISR_RST_BOOST_CFG          8'h00
`define PISR_RST_RESERVED_TRIM      8'h01
`define PISR_RST_RESERVED_SPARE     8'h00
`define PISR_RST_INT_ENABLE_MASK    8'h08
`define PISR_RST_INT_SOURCE_FLAGS   8'h00
`define PISR_RST_UNMAPPED           8'h00

// ****************************************************************
// Field positions and write masks
// ****************************************************************
`define PISR_GAIN_MSB               6
`define PISR_GAIN_LSB               4
`define PISR_FREQ_MSB               3
`define PISR_FREQ_LSB               1
`define PISR_BOOST_MSB              5
`define PISR_BOOST_LSB              3
`define PISR_BOOST_LOW_MSB          2
`define PISR_BOOST_LOW_LSB          0
`define PISR_GAIN_FREQ_WMASK        8'h7E
`define PISR_BOOST_WMASK            8'h3F

// ****************************************************************
// Interrupt mask and source bit positions
// ****************************************************************
`define PISR_BIT_MOTOR_SHORT        7
`define PISR_BIT_NEAR               6
`define PISR_BIT_FAR_OR_DONE        5
`define PISR_BIT_CALIB_DONE         4
`define PISR_BIT_TOUCH              3
`define PISR_BIT_LIFT               2
`define PISR_BIT_THERMAL_WARN       1
`define PISR_BIT_THERMAL_ALARM      0

// ****************************************************************
// Status bit positions
// ****************************************************************
`define PISR_STAT_MOTOR_SHORT       7
`define PISR_STAT_RESET_SEEN        6

// ****************************************************************
// Field codes
// ****************************************************************
`define PISR_FREQ_64K               3'h2
`define PISR_FREQ_90K               3'h3
`define PISR_FREQ_112K              3'h4
`define PISR_FREQ_150K              3'h5
`define PISR_BOOST_ON               3'h4
`define PISR_BOOST_OFF              3'h6
`define PISR_BOOST_LOW_REQUIRED     3'h4
`define PISR_TRIM_REQUIRED          8'h81
`define PISR_INIT_GAIN_FREQ         8'h0A
`define PISR_INIT_BOOST             8'h34

`endif

// ==== pisr_pkg.sv ====
// Types shared by both ends of the proximity/interrupt register block.
// Assumes nothing of its surroundings.
package pisr_pkg;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef logic [7:0] pisr_byte_t;

   typedef enum logic [2:0]
   {
      HS_INIT_FREQ,
      HS_INIT_BOOST,
      HS_INIT_TRIM,
      HS_IDLE,
      HS_READ
   } pisr_host_st_e;

endpackage : pisr_pkg

// ==== pisr_reg_if.sv ====
// Register access channel between the host processor end and the device register block.
// Assumes both ends run on the same ref_clk.
`timescale 1ns/10ps
interface pisr_reg_if;
   import pisr_pkg::*;

   pisr_byte_t reg_addr;
   pisr_byte_t reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   pisr_byte_t reg_rdata;
   logic       reg_rvalid;

   modport dev
   (
      input  reg_addr,
      input  reg_wdata,
      input  reg_wr,
      input  reg_rd,
      output reg_rdata,
      output reg_rvalid
   );

   modport host
   (
      output reg_addr,
      output reg_wdata,
      output reg_wr,
      output reg_rd,
      input  reg_rdata,
      input  reg_rvalid
   );

endinterface : pisr_reg_if

// ==== pisr_device.sv ====
// Device end: proximity front-end settings, interrupt mask and source flags, device status.
// Assumes live status inputs come from logic on ref_clk and the host keeps its own obligations.
//
// Overview of operation
// - Three-bit gain, eight linear sensitivity steps
// - Frequency codes 010..101 valid, others reserved
// - Boost 100 on, 110 off, others reserved
// - Trim word resets 0x01, host writes 0x81
// - Offset byte read-only, read after done
// - Mask bit per source, one enables
// - Mask resets with only touch enabled
// - Source 7 on motor short rising
// - Source 6 on near rising edge
// - Source 5 far edge or prox done
// - Source 4 on calibration pending falling
// - Source 3 touch rising or touch done
// - Source 2 on touch falling edge
// - Source 1 on selected warning edge
// - Source 0 on selected alarm edge
// - Status 7 shows live motor short
// - Status 6 latches reset, read clears
// - Near status one only when close
// - Conversion status one while converting
// - Calibration status one while pending
// - Touch status one while touched
`timescale 1ns/10ps
`include "pisr_regs.svh"
module pisr_device
   import pisr_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // Register access
   pisr_reg_if.dev          bus,
   // Live status from the sensing engine
   input  wire logic        motor_short_live,
   input  wire logic        near_live,
   input  wire logic        prox_sensing_enable,
   input  wire logic        calib_pending_live,
   input  wire logic        conversion_running_live,
   input  wire logic        conversion_is_prox,
   input  wire logic        touch_live,
   input  wire logic        thermal_warn_live,
   input  wire logic        thermal_alarm_live,
   input  wire pisr_byte_t  comp_offset_low_byte,
   // Interrupt configuration
   input  wire logic        far_or_done_select,
   input  wire logic        touch_detect_mode,
   input  wire logic        thermal_warn_edge_select,
   input  wire logic        thermal_alarm_edge_select,
   // Front-end settings
   output logic [2:0]       proximity_gain_level,
   output logic [2:0]       proximity_excitation_freq,
   output logic             freq_code_valid,
   output logic [2:0]       proximity_boost_select,
   output logic             boost_on,
   output pisr_byte_t       prox_trim_word,
   // Interrupt request
   output logic             irq_req
);

   // ****************************************************************
   // Decode helpers
   // ****************************************************************
   function automatic logic hit(input pisr_byte_t a, input pisr_byte_t ofs);
      hit = (a == ofs);
   endfunction : hit

   function automatic logic freq_ok(input logic [2:0] code);
      freq_ok = (code == `PISR_FREQ_64K) || (code == `PISR_FREQ_90K) ||
                (code == `PISR_FREQ_112K) || (code == `PISR_FREQ_150K);
   endfunction : freq_ok

   // ****************************************************************
   // State
   // ****************************************************************
   pisr_byte_t  gain_freq_r,  gain_freq_nxt;
   pisr_byte_t  boost_r,      boost_nxt;
   pisr_byte_t  trim_r,       trim_nxt;
   pisr_byte_t  mask_r,       mask_nxt;
   pisr_byte_t  src_r,        src_nxt;
   logic        reset_seen_r, reset_seen_nxt;
   logic [6:0]  prev_r,       prev_nxt;
   logic        kind_r,       kind_nxt;
   pisr_byte_t  rdata_r,      rdata_nxt;
   logic        rvalid_r,     rvalid_nxt;

   logic [6:0]  live;
   pisr_byte_t  status;
   pisr_byte_t  events;
   logic        near_gated;
   logic        conv_fall;
   logic        wr_hit_any;

   // ****************************************************************
   // Live status and edge events
   // ****************************************************************
   always_comb
   begin
      near_gated = near_live & prox_sensing_enable;
      live       = {motor_short_live, near_gated, calib_pending_live, conversion_running_live,
                    touch_live, thermal_warn_live, thermal_alarm_live};
      status     = {motor_short_live, reset_seen_r, live[5:0]};
      conv_fall  = prev_r[3] & ~conversion_running_live;
      events     = 8'h00;
      events[`PISR_BIT_MOTOR_SHORT] = motor_short_live & ~prev_r[6];
      events[`PISR_BIT_NEAR]        = near_gated & ~prev_r[5];
      events[`PISR_BIT_FAR_OR_DONE] = far_or_done_select ? (conv_fall & kind_r) : (prev_r[5] & ~near_gated);
      events[`PISR_BIT_CALIB_DONE]  = prev_r[4] & ~calib_pending_live;
      events[`PISR_BIT_TOUCH]       = touch_detect_mode ? (touch_live & ~prev_r[2]) : (conv_fall & ~kind_r);
      events[`PISR_BIT_LIFT]        = prev_r[2] & ~touch_live;
      events[`PISR_BIT_THERMAL_WARN] = thermal_warn_edge_select ? (prev_r[1] & ~thermal_warn_live)
                                                                 : (thermal_warn_live & ~prev_r[1]);
      events[`PISR_BIT_THERMAL_ALARM] = thermal_alarm_edge_select ? (prev_r[0] & ~thermal_alarm_live)
                                                                   : (thermal_alarm_live & ~prev_r[0]);
      prev_nxt = live;
      kind_nxt = conversion_running_live ? conversion_is_prox : kind_r;
   end

   // ****************************************************************
   // Register writes, reads and read side effects
   // ****************************************************************
   always_comb
   begin
      gain_freq_nxt  = gain_freq_r;
      boost_nxt      = boost_r;
      trim_nxt       = trim_r;
      mask_nxt       = mask_r;
      rdata_nxt      = rdata_r;
      rvalid_nxt     = 1'b0;
      wr_hit_any     = bus.reg_wr;
      // Sources accumulate until read
      src_nxt        = src_r | events;
      reset_seen_nxt = reset_seen_r;
      if (wr_hit_any)
      begin
         if (hit(bus.reg_addr, `PISR_ADDR_GAIN_FREQ_CFG))
            gain_freq_nxt = bus.reg_wdata & `PISR_GAIN_FREQ_WMASK;
         if (hit(bus.reg_addr, `PISR_ADDR_BOOST_CFG))
            boost_nxt = bus.reg_wdata & `PISR_BOOST_WMASK;
         if (hit(bus.reg_addr, `PISR_ADDR_RESERVED_TRIM))
            trim_nxt = bus.reg_wdata;
         if (hit(bus.reg_addr, `PISR_ADDR_INT_ENABLE_MASK))
            mask_nxt = bus.reg_wdata;
      end
      if (bus.reg_rd)
      begin
         rvalid_nxt = 1'b1;
         case (bus.reg_addr)
            `PISR_ADDR_COMP_OFFSET_LOW:  rdata_nxt = comp_offset_low_byte;
            `PISR_ADDR_GAIN_FREQ_CFG:    rdata_nxt = gain_freq_r;
            `PISR_ADDR_BOOST_CFG:        rdata_nxt = boost_r;
            `PISR_ADDR_RESERVED_TRIM:    rdata_nxt = trim_r;
            `PISR_ADDR_RESERVED_SPARE:   rdata_nxt = `PISR_RST_RESERVED_SPARE;
            `PISR_ADDR_INT_ENABLE_MASK:  rdata_nxt = mask_r;
            `PISR_ADDR_INT_SOURCE_FLAGS: rdata_nxt = src_r;
            `PISR_ADDR_DEVICE_STATUS:    rdata_nxt = status;
            default:                     rdata_nxt = `PISR_RST_UNMAPPED;
         endcase
         // Flags read are cleared, new events in the same cycle survive
         if (hit(bus.reg_addr, `PISR_ADDR_INT_SOURCE_FLAGS))
            src_nxt = events;
         if (hit(bus.reg_addr, `PISR_ADDR_DEVICE_STATUS))
            reset_seen_nxt = 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         gain_freq_r  <= `PISR_RST_GAIN_FREQ_CFG;
         boost_r      <= `PISR_RST_BOOST_CFG;
         trim_r       <= `PISR_RST_RESERVED_TRIM;
         mask_r       <= `PISR_RST_INT_ENABLE_MASK;
         src_r        <= `PISR_RST_INT_SOURCE_FLAGS;
         reset_seen_r <= 1'b1;
         prev_r       <= 7'h00;
         kind_r       <= 1'b0;
         rdata_r      <= 8'h00;
         rvalid_r     <= 1'b0;
      end
      else
      begin
         gain_freq_r  <= gain_freq_nxt;
         boost_r      <= boost_nxt;
         trim_r       <= trim_nxt;
         mask_r       <= mask_nxt;
         src_r        <= src_nxt;
         reset_seen_r <= reset_seen_nxt;
         prev_r       <= prev_nxt;
         kind_r       <= kind_nxt;
         rdata_r      <= rdata_nxt;
         rvalid_r     <= rvalid_nxt;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign bus.reg_rdata               = rdata_r;
   assign bus.reg_rvalid              = rvalid_r;
   assign proximity_gain_level        = gain_freq_r[`PISR_GAIN_MSB:`PISR_GAIN_LSB];
   assign proximity_excitation_freq   = gain_freq_r[`PISR_FREQ_MSB:`PISR_FREQ_LSB];
   assign freq_code_valid             = freq_ok(gain_freq_r[`PISR_FREQ_MSB:`PISR_FREQ_LSB]);
   assign proximity_boost_select      = boost_r[`PISR_BOOST_MSB:`PISR_BOOST_LSB];
   assign boost_on                    = (boost_r[`PISR_BOOST_MSB:`PISR_BOOST_LSB] == `PISR_BOOST_ON);
   assign prox_trim_word              = trim_r;
   assign irq_req                     = |(src_r & mask_r);

endmodule : pisr_device

// ==== pisr_monitor.sv ====
// Checker for the register channel between the host and device ends.
// Assumes it is instantiated beside the interface, on the single ref_clk.
`timescale 1ns/10ps
module pisr_monitor
   import pisr_pkg::*;
(
   // Clock and reset
   input wire logic       ref_clk,
   input wire logic       rst_n,
   // Register channel
   input wire pisr_byte_t reg_addr,
   input wire pisr_byte_t reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire pisr_byte_t reg_rdata,
   input wire logic       reg_rvalid
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // ****************
   // Assertions
   // ****************
   rd_answer_a: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered");
   rd_quiet_a: assert property (!reg_rd |=> !reg_rvalid)
      else $error("stray read answer");
   hole_zero_a: assert property (reg_rd && reg_addr == 8'h1E |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   gain_rsvd_a: assert property (reg_rd && reg_addr == 8'h1D |=> !reg_rdata[7] && !reg_rdata[0])
      else $error("gain word spare bits set");
   boost_rsvd_a: assert property (reg_rd && reg_addr == 8'h1F |=>
      reg_rdata[7:6] == 2'h0 && reg_rdata[2:0] == 3'h4)
      else $error("boost word fixed bits wrong");
   trim_init_a: assert property ($rose(rst_n) |-> ##[1:4]
      (reg_wr && reg_addr == 8'h20 && reg_wdata == 8'h81))
      else $error("trim word not programmed");
   offs_nowr_a: assert property (!(reg_wr && reg_addr == 8'h1C))
      else $error("offset byte written");
   mask_rw_a: assert property ((reg_wr && reg_addr == 8'h22) ##2 (reg_rd && reg_addr == 8'h22)
      |=> reg_rdata == $past(reg_wdata, 3))
      else $error("mask readback wrong");
   latch_clr_a: assert property ((reg_rd && reg_addr == 8'h24) ##[2:30] (reg_rd && reg_addr == 8'h24)
      |=> !reg_rdata[6])
      else $error("reset latch not cleared");
   cover property (reg_rd && reg_addr == 8'h23);
   cover property (reg_wr && reg_addr == 8'h22);
   cover property (reg_rd && reg_addr == 8'h1C);
endmodule : pisr_monitor

// ==== prox_irq_status_regs_tb.sv ====
// Testbench joining host and device ends, driving the user port and live status.
// Assumes the design files and the interface are compiled first.
`timescale 1ns/10ps
module prox_irq_status_regs_tb;
   import pisr_pkg::*;
   logic       ref_clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, cmd_write = 1'b0, tsens = 1'b0, pdone = 1'b0;
   logic       cmd_ready, resp_valid, resp_refused, init_done, fv, bo, irq;
   logic [2:0] gain, frq, bsel;
   logic [8:0] lv = 9'h040;
   logic [3:0] cfg = 4'h4;
   pisr_byte_t cmd_addr = 8'h00, cmd_wdata = 8'h00, resp_data, trim;
   int         mismatches = 0, samples_checked = 0, n;
   logic [8:0] tl [13] = '{9'h140, 9'h1C0, 9'h140, 9'h160, 9'h140, 9'h144, 9'h140, 9'h143, 9'h140,
                           9'h158, 9'h148, 9'h150, 9'h140};
   logic [3:0] tc [13] = '{4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h7, 4'h8, 4'h8, 4'h8, 4'h8};
   pisr_byte_t te [13] = '{8'h80, 8'h40, 8'h20, 8'h00, 8'h10, 8'h08, 8'h04, 8'h03, 8'h03, 8'h00, 8'h20,
                           8'h00, 8'h08};
   pisr_reg_if u_pisr_reg_if ();
   pisr_device u_pisr_device (.ref_clk(ref_clk), .rst_n(rst_n), .bus(u_pisr_reg_if.dev),
      .motor_short_live(lv[8]), .near_live(lv[7]), .prox_sensing_enable(lv[6]), .calib_pending_live(lv[5]),
      .conversion_running_live(lv[4]), .conversion_is_prox(lv[3]), .touch_live(lv[2]),
      .thermal_warn_live(lv[1]), .thermal_alarm_live(lv[0]), .comp_offset_low_byte(8'hA5),
      .far_or_done_select(cfg[3]), .touch_detect_mode(cfg[2]), .thermal_warn_edge_select(cfg[1]),
      .thermal_alarm_edge_select(cfg[0]), .proximity_gain_level(gain), .proximity_excitation_freq(frq),
      .freq_code_valid(fv), .proximity_boost_select(bsel), .boost_on(bo), .prox_trim_word(trim), .irq_req(irq));
   pisr_host u_pisr_host (.ref_clk(ref_clk), .rst_n(rst_n), .bus(u_pisr_reg_if.host), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
      .resp_valid(resp_valid), .resp_refused(resp_refused), .resp_data(resp_data),
      .touchscreen_is_sensor(tsens), .prox_conversion_done(pdone), .init_done(init_done));
   pisr_monitor u_pisr_monitor (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(u_pisr_reg_if.reg_addr),
      .reg_wdata(u_pisr_reg_if.reg_wdata), .reg_wr(u_pisr_reg_if.reg_wr), .reg_rd(u_pisr_reg_if.reg_rd),
      .reg_rdata(u_pisr_reg_if.reg_rdata), .reg_rvalid(u_pisr_reg_if.reg_rvalid));
   // ****************
   // Tasks
   // ****************
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Expected value is {refused, read data}; data ignored for writes and refusals
   task automatic op(input logic w, input pisr_byte_t a, input pisr_byte_t d, input logic [8:0] e);
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_addr <= a;
      cmd_wdata <= d;
      #1;
      for (n = 0; n < 9 && !cmd_ready; n++) @(posedge ref_clk) #1;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      #1;
      for (n = 0; n < 9 && !resp_valid; n++) @(posedge ref_clk) #1;
      chk({8'h00, resp_valid}, 9'h001);
      chk({resp_refused, (w || e[8]) ? e[7:0] : resp_data}, e);
   endtask : op
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   // ****************
   // Sequence
   // ****************
   initial forever #5 ref_clk = ~ref_clk;
   initial
   begin
      #50000;
      mismatches++;
      end_sim();
   end
   initial
   begin
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (n = 0; n < 20 && init_done !== 1'b1; n++) @(posedge ref_clk) #1;
      chk({8'h00, init_done}, 9'h001);
      op(0, 8'h24, 0, 9'h040);
      op(0, 8'h24, 0, 9'h000);
      chk({1'b0, trim}, 9'h081);
      chk({6'h00, frq}, 9'h005);
      chk({6'h00, bsel}, 9'h006);
      op(0, 8'h22, 0, 9'h008);
      op(0, 8'h20, 0, 9'h081);
      op(0, 8'h1D, 0, 9'h00A);
      op(0, 8'h1F, 0, 9'h034);
      op(0, 8'h21, 0, 9'h000);
      op(0, 8'h1E, 0, 9'h000);
      op(1, 8'h1D, 8'h7E, 9'h100);
      for (int i = 2; i < 6; i++)
      begin
         op(1, 8'h1D, {1'b1, {3{i[0]}}, 3'(i), 1'b1}, 9'h000);
         op(0, 8'h1D, 0, {2'b00, {3{i[0]}}, 3'(i), 1'b0});
         chk({8'h00, fv}, 9'h001);
         chk({6'h00, frq}, {6'h00, 3'(i)});
         chk({6'h00, gain}, {6'h00, {3{i[0]}}});
      end
      op(1, 8'h1F, 8'hE0, 9'h000);
      op(0, 8'h1F, 0, 9'h024);
      chk({8'h00, bo}, 9'h001);
      chk({6'h00, bsel}, 9'h004);
      op(1, 8'h1F, 8'h38, 9'h100);
      @(posedge ref_clk);
      tsens <= 1'b1;
      op(1, 8'h1F, 8'h20, 9'h000);
      op(0, 8'h1F, 0, 9'h034);
      op(0, 8'h1C, 0, 9'h100);
      op(1, 8'h1C, 8'h11, 9'h100);
      @(posedge ref_clk);
      pdone <= 1'b1;
      @(posedge ref_clk);
      pdone <= 1'b0;
      op(0, 8'h1C, 0, 9'h0A5);
      for (int k = 0; k < 13; k++)
      begin
         @(posedge ref_clk);
         lv <= tl[k];
         cfg <= tc[k];
         repeat (2) @(posedge ref_clk);
         #1;
         chk({8'h00, irq}, {8'h00, te[k][3]});
         op(0, 8'h23, 0, {1'b0, te[k]});
         op(0, 8'h24, 0, {1'b0, lv[8], 1'b0, &lv[7:6], lv[5:4], lv[2:0]});
      end
      op(0, 8'h24, 0, 9'h080);
      op(1, 8'h22, 8'hA5, 9'h000);
      op(0, 8'h22, 0, 9'h0A5);
      chk({8'h00, irq}, 9'h000);
      @(posedge ref_clk);
      lv <= 9'h181;
      repeat (2) @(posedge ref_clk);
      #1;
      chk({8'h00, irq}, 9'h001);
      op(0, 8'h24, 0, 9'h081);
      op(0, 8'h23, 0, 9'h001);
      end_sim();
   end
endmodule : prox_irq_status_regs_tb
